// File: core/dct_bcd_counter.sv
// eight-decade bcd counter with stretched wrap pulse
`timescale 1ns/10ps
`default_nettype none
module dct_bcd_counter
  import dct_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control side
  dct_count_if.cnt port
);
  logic [DECADES:0] carry;
  logic [7:0] pulse_cnt_reg;

  assign carry[0] = port.inc;

  // ----------------------------------------
  // decade chain
  // ----------------------------------------
  genvar d;
  generate
    for (d = 0; d < DECADES; d++) begin : g_dec
      logic [3:0] digit_reg;
      assign carry[d+1] = carry[d] && (digit_reg == 4'h9);
      // each digit rolls 9 to 0 and passes the carry on
      always_ff @(posedge aclk) begin
        if (!aresetn || port.clr) begin
          digit_reg <= 4'h0;
        end else if (carry[d]) begin
          digit_reg <= (digit_reg == 4'h9) ? 4'h0 : digit_reg + 4'h1;
        end
      end
      assign port.value[4*d+3:4*d] = digit_reg;
    end
  endgenerate

  // stretch wrap pulse
  // restarts on a new wrap; wraps closer than the pulse merge into one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_cnt_reg <= 8'h00;
    end else if (carry[DECADES]) begin
      pulse_cnt_reg <= 8'(OVF_PULSE_CYCLES);
    end else if (pulse_cnt_reg != 8'h00) begin
      pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
    end
  end
  assign port.ovf_pulse = (pulse_cnt_reg != 8'h00);
endmodule
`default_nettype wire

// File: core/dct_count_if.sv
// carrier between the control logic and one eight-decade counter
`timescale 1ns/10ps
`default_nettype none
interface dct_count_if;
  logic inc;
  logic clr;
  logic [31:0] value;
  logic ovf_pulse;
  modport ctl (output inc, output clr, input value, input ovf_pulse);
  modport cnt (input inc, input clr, output value, output ovf_pulse);
endinterface
`default_nettype wire

// File: core/dct_pkg.sv
// constants and types shared by the dual counter and preset timer
package dct_pkg;
  // ----------------------------------------
  // clock and time figures
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TB_SEC_PERIOD_US = 10000; // hundredth of a second
  localparam int TB_SEC_CYCLES = TB_SEC_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int TB_MIN_PERIOD_MS = 600; // hundredth of a minute
  localparam int TB_MIN_RATIO = TB_MIN_PERIOD_MS * 1000 / TB_SEC_PERIOD_US;
  localparam int DWELL_UNIT_MS = 1000; // one dwell step
  localparam int DWELL_UNIT_TICKS = DWELL_UNIT_MS * 1000 / TB_SEC_PERIOD_US;
  localparam int DWELL_MAX_UNITS = 10;
  localparam int OVF_PULSE_US = 20;
  localparam int OVF_PULSE_CYCLES = OVF_PULSE_US * 1000 / CLK_PERIOD_NS;
  localparam int DECADES = 8;
  localparam int NUM_PINS = 15;

  // ----------------------------------------
  // register map and reset values
  // ----------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_COUNT_A = 4'h8;
  localparam logic [3:0] ADDR_COUNT_B = 4'hc;
  localparam int CTRL_DWELL_LSB = 0;
  localparam int CTRL_COUNT_BIT = 4;
  localparam int CTRL_STOP_BIT = 5;
  localparam int CTRL_RESET_BIT = 6;
  localparam logic [3:0] CTRL_DWELL_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // pin positions in the synchroniser vector
  // ----------------------------------------
  localparam int PIN_IN_A = 0;
  localparam int PIN_IN_B = 1;
  localparam int PIN_ENABLE = 2;
  localparam int PIN_GATE_A = 3;
  localparam int PIN_GATE_B = 4;
  localparam int PIN_LIVE = 5;
  localparam int PIN_SRC_A = 6;
  localparam int PIN_SRC_B = 7;
  localparam int PIN_BTN_COUNT = 8;
  localparam int PIN_BTN_STOP = 9;
  localparam int PIN_BTN_RESET = 10;
  localparam int PIN_BTN_TB = 11;
  localparam int PIN_BTN_DISP = 12;
  localparam int PIN_BTN_DIGIT = 13;
  localparam int PIN_BTN_ADV = 14;

  // ----------------------------------------
  // state types
  // ----------------------------------------
  typedef enum logic [3:0] {
    RUN_STOPPED = 4'h1, RUN_COUNTING = 4'h2, RUN_HOLD = 4'h4, RUN_DWELL = 4'h8
  } dct_run_type;
  typedef enum logic [2:0] {TB_SEC = 3'h1, TB_MIN = 3'h2, TB_EXT = 3'h4} dct_tb_type;
  typedef enum logic [2:0] {DISP_A = 3'h1, DISP_B = 3'h2, DISP_PRESET = 3'h4} dct_disp_type;
  typedef enum logic [2:0] {DIG_HIGH = 3'h1, DIG_LOW = 3'h2, DIG_SHIFT = 3'h4} dct_digit_type;
endpackage

// File: core/dct_sync.sv
// three-flop synchroniser with agreement filter and rise pulse per pin
`timescale 1ns/10ps
`default_nettype none
module dct_sync
  import dct_pkg::*;
#(
  parameter int WIDTH = NUM_PINS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // raw pins and conditioned results
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);
  // ----------------------------------------
  // per-pin conditioning
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      logic s1_reg, s2_reg, s3_reg, lvl_reg;
      // first flop feeds only the second, so metastability stays contained
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
        end else begin
          s1_reg <= pin[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
        end
      end
      // a change counts once second and third agree
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          lvl_reg <= 1'b0;
        end else if (s2_reg == s3_reg) begin
          lvl_reg <= s3_reg;
        end
      end
      assign level[i] = lvl_reg;
      assign rise[i] = (s2_reg == s3_reg) && s3_reg && !lvl_reg;
    end
  endgenerate
endmodule
`default_nettype wire

// File: core/dct_top.sv
// dual eight-decade counter with preset timer and register slave
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module dct_top
  import dct_pkg::*;
#(
  parameter int TB_CYCLES = TB_SEC_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // counting pins and straps
  input wire logic count_in_a,
  input wire logic count_in_b,
  input wire logic enable_in,
  input wire logic gate_a_in,
  input wire logic gate_b_in,
  input wire logic live_time_strap,
  input wire logic counter_a_source_strap,
  input wire logic counter_b_source_strap,
  // push buttons, active high while pressed
  input wire logic btn_count,
  input wire logic btn_stop,
  input wire logic btn_reset,
  input wire logic btn_timebase,
  input wire logic btn_display,
  input wire logic btn_digit,
  input wire logic btn_advance,
  // outputs
  output logic interval_out,
  output logic overflow_a,
  output logic overflow_b,
  output logic [31:0] display_value,
  output logic [2:0] timebase_led,
  output logic [2:0] display_led,
  output logic [2:0] digit_led
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [NUM_PINS-1:0] pins, lvl, rise;
  dct_run_type run_reg;
  dct_tb_type tb_reg;
  dct_disp_type disp_reg;
  dct_digit_type digit_reg;
  logic [3:0] hi_reg, lo_reg, shift_reg, dwell_cfg_reg;
  logic [16:0] presc_reg;
  logic [5:0] min_div_reg;
  logic sec_tick, min_tick, tb_tick;
  logic [39:0] pcnt_reg, target;
  logic [10:0] dwell_cnt_reg;
  logic [10:0] dwell_len;
  logic preset_on, preset_ev, preset_hit, dwell_done;
  logic run_ok, timer_gate, inc_a, inc_b, clear_all;
  logic cmd_count, cmd_stop, cmd_reset;
  logic rem_count_reg, rem_stop_reg, rem_reset_reg;
  logic [3:0] awaddr_reg;
  logic aw_full_reg, w_full_reg, wstrb0_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic bvalid_reg, rvalid_reg;
  logic [31:0] status_word;

  dct_count_if cnt_a_if ();
  dct_count_if cnt_b_if ();

  // ----------------------------------------
  // pin conditioning
  // ----------------------------------------
  // sync and edge detect
  assign pins = {btn_advance, btn_digit, btn_display, btn_timebase, btn_reset,
    btn_stop, btn_count, counter_b_source_strap, counter_a_source_strap,
    live_time_strap, gate_b_in, gate_a_in, enable_in, count_in_b, count_in_a};

  dct_sync #(.WIDTH(NUM_PINS)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(pins),
    .level(lvl),
    .rise(rise)
  );

  // commands from buttons or from the control register
  assign cmd_count = rise[PIN_BTN_COUNT] || rem_count_reg;
  assign cmd_stop = rise[PIN_BTN_STOP] || rem_stop_reg;
  assign cmd_reset = rise[PIN_BTN_RESET] || rem_reset_reg;

  // ----------------------------------------
  // time bases
  // ----------------------------------------
  // prescaler from system clock
  always_ff @(posedge aclk) begin
    if (!aresetn || presc_reg == 17'(TB_CYCLES - 1)) begin
      presc_reg <= 17'h00000;
    end else begin
      presc_reg <= presc_reg + 17'h00001;
    end
  end
  assign sec_tick = (presc_reg == 17'(TB_CYCLES - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      min_div_reg <= 6'h00;
    end else if (sec_tick) begin
      min_div_reg <= (min_div_reg == 6'(TB_MIN_RATIO - 1)) ? 6'h00 : min_div_reg + 6'h01;
    end
  end
  assign min_tick = sec_tick && (min_div_reg == 6'(TB_MIN_RATIO - 1));
  assign tb_tick = (tb_reg == TB_MIN) ? min_tick : sec_tick;

  // ----------------------------------------
  // front-panel selections
  // ----------------------------------------
  // time-base select steps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tb_reg <= TB_SEC;
    end else if (rise[PIN_BTN_TB]) begin
      unique case (tb_reg)
        TB_SEC: tb_reg <= TB_MIN;
        TB_MIN: tb_reg <= TB_EXT;
        TB_EXT: tb_reg <= TB_SEC;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      disp_reg <= DISP_A;
    end else if (rise[PIN_BTN_DISP]) begin
      unique case (disp_reg)
        DISP_A: disp_reg <= DISP_B;
        DISP_B: disp_reg <= DISP_PRESET;
        DISP_PRESET: disp_reg <= DISP_A;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      digit_reg <= DIG_HIGH;
    end else if (rise[PIN_BTN_DIGIT] && disp_reg == DISP_PRESET) begin
      unique case (digit_reg)
        DIG_HIGH: digit_reg <= DIG_LOW;
        DIG_LOW: digit_reg <= DIG_SHIFT;
        DIG_SHIFT: digit_reg <= DIG_HIGH;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_reg <= 4'h0;
      lo_reg <= 4'h0;
      shift_reg <= 4'h0;
    end else if (rise[PIN_BTN_ADV] && disp_reg == DISP_PRESET) begin
      if (digit_reg == DIG_HIGH) begin
        hi_reg <= (hi_reg == 4'h9) ? 4'h0 : hi_reg + 4'h1;
      end
      if (digit_reg == DIG_LOW) begin
        lo_reg <= (lo_reg == 4'h9) ? 4'h0 : lo_reg + 4'h1;
      end
      if (digit_reg == DIG_SHIFT) begin
        shift_reg <= (shift_reg == 4'h9) ? 4'h0 : shift_reg + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // preset counter
  // ----------------------------------------
  // two digits times ten power
  always_comb begin
    target = 40'(hi_reg) * 40'd10 + 40'(lo_reg);
    for (int k = 0; k < 9; k++) begin
      if (4'(k) < shift_reg) begin
        target = target * 40'd10;
      end
    end
  end
  assign preset_on = (hi_reg != 4'h0) || (lo_reg != 4'h0);

  assign run_ok = (run_reg == RUN_COUNTING) && lvl[PIN_ENABLE];
  // live strap lets gate A stop timer
  assign timer_gate = run_ok && (!lvl[PIN_LIVE] || lvl[PIN_GATE_A]);
  // external mode uses input A pulses
  assign preset_ev = timer_gate && ((tb_reg == TB_EXT) ? rise[PIN_IN_A] : tb_tick);
  assign preset_hit = preset_on && preset_ev && (pcnt_reg + 40'd1 >= target);

  always_ff @(posedge aclk) begin
    if (!aresetn || clear_all) begin
      pcnt_reg <= 40'd0;
    end else if (preset_ev) begin
      pcnt_reg <= pcnt_reg + 40'd1;
    end
  end

  // ----------------------------------------
  // dwell timer
  // ----------------------------------------
  // dwell length in hundredth-second ticks
  assign dwell_len = (dwell_cfg_reg > 4'(DWELL_MAX_UNITS)) ?
    11'(DWELL_MAX_UNITS * DWELL_UNIT_TICKS) : 11'(dwell_cfg_reg) * 11'(DWELL_UNIT_TICKS);
  assign dwell_done = (run_reg == RUN_DWELL) && sec_tick && (dwell_cnt_reg + 11'd1 >= dwell_len);

  always_ff @(posedge aclk) begin
    if (!aresetn || run_reg != RUN_DWELL) begin
      dwell_cnt_reg <= 11'd0;
    end else if (sec_tick) begin
      dwell_cnt_reg <= dwell_cnt_reg + 11'd1;
    end
  end

  // ----------------------------------------
  // run control
  // ----------------------------------------
  // dwell expiry acts as a reset
  assign clear_all = cmd_reset || dwell_done;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_reg <= RUN_STOPPED;
    end else begin
      unique case (run_reg)
        RUN_STOPPED: begin
          if (cmd_count && !cmd_stop) begin
            run_reg <= RUN_COUNTING;
          end
        end
        RUN_COUNTING: begin
          if (cmd_stop) begin
            run_reg <= RUN_STOPPED;
          end else if (preset_hit) begin
            run_reg <= (dwell_cfg_reg == 4'h0) ? RUN_HOLD : RUN_DWELL;
          end
        end
        RUN_HOLD: begin
          if (cmd_reset) begin
            run_reg <= RUN_STOPPED;
          end
        end
        RUN_DWELL: begin
          if (cmd_reset || cmd_stop) begin
            run_reg <= RUN_STOPPED;
          end else if (dwell_done) begin
            run_reg <= RUN_COUNTING;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // counters
  // ----------------------------------------
  // live mode A counts gated time
  // gate A gates counter A, never counter B; in live mode it also gates the preset timer
  always_comb begin
    if (lvl[PIN_LIVE]) begin
      inc_a = timer_gate && tb_tick;
    end else if (lvl[PIN_SRC_A] || tb_reg == TB_EXT) begin
      inc_a = run_ok && lvl[PIN_GATE_A] && rise[PIN_IN_A];
    end else begin
      inc_a = run_ok && lvl[PIN_GATE_A] && tb_tick;
    end
  end

  assign inc_b = run_ok && lvl[PIN_GATE_B] &&
    ((lvl[PIN_SRC_B] || tb_reg != TB_EXT) ? rise[PIN_IN_B] : sec_tick);

  assign cnt_a_if.inc = inc_a;
  assign cnt_a_if.clr = clear_all;
  assign cnt_b_if.inc = inc_b;
  assign cnt_b_if.clr = clear_all;

  dct_bcd_counter u_cnt_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .port(cnt_a_if.cnt)
  );
  dct_bcd_counter u_cnt_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .port(cnt_b_if.cnt)
  );
  assign overflow_a = cnt_a_if.ovf_pulse;
  assign overflow_b = cnt_b_if.ovf_pulse;

  // ----------------------------------------
  // panel outputs
  // ----------------------------------------
  // interval follows the counting gate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interval_out <= 1'b0;
      display_value <= 32'h00000000;
    end else begin
      interval_out <= timer_gate && !preset_hit && !cmd_stop;
      unique case (disp_reg)
        DISP_A: display_value <= cnt_a_if.value;
        DISP_B: display_value <= cnt_b_if.value;
        DISP_PRESET: display_value <= {20'h00000, hi_reg, lo_reg, shift_reg};
      endcase
    end
  end
  assign timebase_led = tb_reg;
  assign display_led = disp_reg;
  assign digit_led = digit_reg;

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready = !w_full_reg && !bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rvalid = rvalid_reg;

  // address and data are caught in either order, answered once both held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h00000000;
      wstrb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (aw_full_reg && w_full_reg) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      bvalid_reg <= 1'b1;
      bresp_reg <= (awaddr_reg == ADDR_CTRL) ? RESP_OKAY : RESP_SLVERR;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[3:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        // strobe is caught with the data: the master may drop it once taken
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // control register: dwell length and one-cycle remote commands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dwell_cfg_reg <= CTRL_DWELL_RST;
      rem_count_reg <= 1'b0;
      rem_stop_reg <= 1'b0;
      rem_reset_reg <= 1'b0;
    end else begin
      rem_count_reg <= 1'b0;
      rem_stop_reg <= 1'b0;
      rem_reset_reg <= 1'b0;
      if (aw_full_reg && w_full_reg && awaddr_reg == ADDR_CTRL && wstrb0_reg) begin
        dwell_cfg_reg <= wdata_reg[CTRL_DWELL_LSB+3:CTRL_DWELL_LSB];
        rem_count_reg <= wdata_reg[CTRL_COUNT_BIT];
        rem_stop_reg <= wdata_reg[CTRL_STOP_BIT];
        rem_reset_reg <= wdata_reg[CTRL_RESET_BIT];
      end
    end
  end

  // status: run state, selections, preset digits
  assign status_word = {6'h00, shift_reg, lo_reg, hi_reg, 1'b0, digit_reg,
    disp_reg, tb_reg, run_reg};

  // reads answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      unique case ({s_axi_araddr[3:2], 2'b00})
        ADDR_CTRL: rdata_reg <= {28'h0000000, dwell_cfg_reg};
        ADDR_STATUS: rdata_reg <= status_word;
        ADDR_COUNT_A: rdata_reg <= cnt_a_if.value;
        ADDR_COUNT_B: rdata_reg <= cnt_b_if.value;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: verification/dct_checker.sv
// assertions on the top ports of the dual counter
`timescale 1ns/10ps
`default_nettype none
module dct_checker
  import dct_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic enable_in,
  input wire logic interval_out,
  input wire logic overflow_a,
  input wire logic [2:0] timebase_led,
  input wire logic [2:0] display_led,
  input wire logic [2:0] digit_led
);
  // pulse length, cleared while low so a stuck pulse shows up as too long
  logic [8:0] ovf_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn || !overflow_a) ovf_cnt <= 9'h0;
    else ovf_cnt <= ovf_cnt + 9'h1;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_rst_idle: assert property ($rose(aresetn) |-> !interval_out && !overflow_a
    && display_led == 3'h1 && timebase_led == 3'h1 && digit_led == 3'h1) else $error("bad reset");
  a_enable_stop: assert property (!enable_in [*8] |-> !interval_out)
    else $error("interval open while disabled");
  a_ovf_width: assert property ($fell(overflow_a) |-> ovf_cnt == 9'hc8)
    else $error("overflow pulse width");
  a_led_onehot: assert property ($onehot(timebase_led) && $onehot(display_led)
    && $onehot(digit_led)) else $error("indicator not one-hot");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data moved");
  c_preset_end: cover property ($fell(interval_out));
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_show_preset: cover property (display_led == 3'h4);
endmodule
bind dct_top dct_checker dct_checker_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .enable_in,
  .interval_out, .overflow_a, .timebase_led, .display_led, .digit_led);
`default_nettype wire

// File: verification/dct_partner.sv
// pulse sources and push buttons in front of the counter
`timescale 1ns/10ps
`default_nettype none
module dct_partner (
  // clock
  input wire logic clk,
  // input a, input b, then the seven buttons
  output logic [8:0] pins
);
  initial pins = 9'h0;
  // one clean rise per press, long enough to pass the filter
  task automatic hit(input int k, input int n);
    repeat (n) begin
      @(posedge clk);
      pins[k] <= 1'b1;
      repeat (3) @(posedge clk);
      pins[k] <= 1'b0;
      repeat (5) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// File: verification/dct_top_bench.sv
// self-checking bench for the dual counter and preset timer
`timescale 1ns/10ps
`default_nettype none
module dct_top_bench
  import dct_pkg::*;
;
  localparam int K_CNT = 2, K_STP = 3, K_RST = 4, K_TB = 5, K_DSP = 6, K_DIG = 7, K_ADV = 8;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0, en = 1'b1, gb = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, interval_out, overflow_a, ga = 1'b1;
  logic [31:0] wdata = 32'h0, rdata, display_value, rd;
  logic [1:0] bresp, rresp, resp;
  logic [2:0] timebase_led, display_led, digit_led;
  logic [8:0] pins;
  int num_errors = 0, cmp_count = 0, seed = 76898, n, m, i;
  always #50 aclk = ~aclk;
  dct_partner dct_partner_i (.clk(aclk), .pins(pins));
  // straps fixed: normal mode, a counts time, b counts input
  dct_top #(.TB_CYCLES(10)) dct_top_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .count_in_a(pins[0]), .count_in_b(pins[1]), .enable_in(en),
    .gate_a_in(ga), .gate_b_in(gb), .live_time_strap(1'b0), .counter_a_source_strap(1'b0),
    .counter_b_source_strap(1'b1), .btn_count(pins[2]), .btn_stop(pins[3]),
    .btn_reset(pins[4]), .btn_timebase(pins[5]), .btn_display(pins[6]), .btn_digit(pins[7]),
    .btn_advance(pins[8]), .interval_out(interval_out), .overflow_a(overflow_a),
    .overflow_b(), .display_value(display_value), .timebase_led(timebase_led),
    .display_led(display_led), .digit_led(digit_led));
  function automatic logic [31:0] bcd(input int v);
    logic [31:0] r;
    r = 32'h0;
    for (int k = 0; k < 8; k++) begin
      r[4*k +: 4] = 4'(v % 10);
      v = v / 10;
    end
    return r;
  endfunction
  task automatic summarize;
    if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tmo;
    num_errors++;
    summarize();
  endtask
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    cmp_count++;
    if (act !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, act, exp);
    end
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
      if (bvalid) break;
    end
    if (k == 50) tmo();
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a, output logic [31:0] d);
    int k;
    @(posedge aclk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arready) arv <= 1'b0;
      if (rvalid) break;
    end
    if (k == 50) tmo();
    d = rdata;
    rready <= 1'b0;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'({timebase_led, display_led, digit_led, interval_out}), 32'h92);
    rdr(ADDR_STATUS, rd);
    chk(32'(rd[3:0]), 32'h1);
    wr(ADDR_COUNT_A, 32'h1, resp);
    chk(32'(resp), 32'(RESP_SLVERR));
    for (i = 1; i <= 3; i++) begin
      dct_partner_i.hit(K_TB, 1);
      chk(32'(timebase_led), 32'(3'h1 << (i % 3)));
    end
    for (i = 1; i <= 2; i++) begin
      dct_partner_i.hit(K_DSP, 1);
      chk(32'(display_led), 32'(3'h1 << i));
    end
    // preset of ten ticks: high digit 1, low 0, shift 0
    dct_partner_i.hit(K_ADV, 1);
    dct_partner_i.hit(K_DIG, 1);
    chk(32'(digit_led), 32'h2);
    chk(display_value, 32'h100);
    // stop, reset, count begins a fresh cycle
    dct_partner_i.hit(K_STP, 1);
    dct_partner_i.hit(K_RST, 1);
    dct_partner_i.hit(K_CNT, 1);
    chk(32'(interval_out), 32'h1);
    for (i = 0; i < 5000 && interval_out !== 1'b0; i++) @(posedge aclk);
    if (i == 5000) tmo();
    repeat (50) @(posedge aclk);
    rdr(ADDR_COUNT_A, rd);
    chk(rd, bcd(10));
    rdr(ADDR_STATUS, rd);
    chk(32'(rd[3:0]), 32'h4);
    // high digit wraps back to zero, which turns the preset off
    dct_partner_i.hit(K_RST, 1);
    dct_partner_i.hit(K_DIG, 2);
    dct_partner_i.hit(K_ADV, 9);
    chk(display_value, 32'h0);
    n = 1 + ($unsigned($random(seed)) % 12);
    m = 1 + ($unsigned($random(seed)) % 12);
    dct_partner_i.hit(K_CNT, 1);
    dct_partner_i.hit(1, n);
    dct_partner_i.hit(K_STP, 1);
    dct_partner_i.hit(1, 3);
    dct_partner_i.hit(K_CNT, 1);
    dct_partner_i.hit(1, m);
    rdr(ADDR_COUNT_B, rd);
    chk(rd, bcd(n + m));
    // pulses while disabled or gated must be lost
    en <= 1'b0;
    repeat (8) @(posedge aclk);
    chk(32'(interval_out), 32'h0);
    dct_partner_i.hit(1, 2);
    en <= 1'b1;
    gb <= 1'b0;
    repeat (8) @(posedge aclk);
    dct_partner_i.hit(1, 2);
    gb <= 1'b1;
    rdr(ADDR_COUNT_B, rd);
    chk(rd, bcd(n + m));
    // gate a closed leaves counter b counting
    ga <= 1'b0;
    repeat (8) @(posedge aclk);
    dct_partner_i.hit(1, 2);
    ga <= 1'b1;
    rdr(ADDR_COUNT_B, rd);
    chk(rd, bcd(n + m + 2));
    // dwell length lands, remote stop leaves the run state stopped
    wr(ADDR_CTRL, 32'h23, resp);
    chk(32'(resp), 32'(RESP_OKAY));
    rdr(ADDR_CTRL, rd);
    chk(rd, 32'h3);
    rdr(ADDR_STATUS, rd);
    chk(32'(rd[3:0]), 32'h1);
    summarize();
  end
endmodule
`default_nettype wire
